//--- logic/asf_sample_fifo.v
`timescale 1ns/100ps
`include "asf_fifo_defs.vh"
`default_nettype none

module asf_sample_fifo
#(
  parameter DEPTH = `ASF_DEPTH,
  parameter AW    = `ASF_ADDR_W,
  parameter CW    = `ASF_CNT_W
)
(
  input  wire          clk_sys,
  input  wire          rstn,
  input  wire          reg_wr_en,
  input  wire          reg_rd_en,
  input  wire [7:0]    reg_addr,
  input  wire [7:0]    reg_wdata,
  output reg  [7:0]    reg_rdata,
  input  wire          smp_valid,
  input  wire [11:0]   smp_x,
  input  wire [11:0]   smp_y,
  input  wire [11:0]   smp_z,
  input  wire [11:0]   smp_t,
  input  wire          act_event,
  input  wire          rd_cmd_start,
  input  wire          rd_byte_req,
  output reg  [7:0]    rd_byte_data,
  output reg           rd_byte_valid,
  output reg           flag_ready,
  output reg           flag_watermark,
  output reg           flag_overrun,
  output reg  [CW-1:0] level
);

  // ==========================================================
  // Reset release
  reg       rst_s1;
  reg       rst_s2;
  wire      rst_n;

  // Async assert, clocked release so no flop leaves reset on a ragged edge
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  assign rst_n = rst_s2;

  // ==========================================================
  // Configuration registers
  reg  [7:0] ctl;
  reg  [7:0] smp_cnt;
  wire [1:0] mode;
  wire       temp_en;
  wire [8:0] wm_lvl;

  assign mode    = ctl[`ASF_CTL_MODE_MSB:`ASF_CTL_MODE_LSB];
  assign temp_en = ctl[`ASF_CTL_TEMP_BIT];
  assign wm_lvl  = {ctl[`ASF_CTL_HIGH_BIT], smp_cnt};

  // Writes to the two configuration offsets
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl     <= `ASF_RST_CONTROL;
      smp_cnt <= `ASF_RST_SAMPLE_COUNT;
    end
    else if (reg_wr_en)
    begin
      if (reg_addr == `ASF_ADDR_CONTROL)
        ctl <= {4'h0, reg_wdata[3:0]};
      if (reg_addr == `ASF_ADDR_SAMPLE_COUNT)
        smp_cnt <= reg_wdata;
    end
  end

  // Register read data; unmapped offsets answer zero
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd_en)
      case (reg_addr)
        `ASF_ADDR_CONTROL:      reg_rdata <= ctl;
        `ASF_ADDR_SAMPLE_COUNT: reg_rdata <= smp_cnt;
        default:                reg_rdata <= 8'h00;
      endcase
  end

  // ==========================================================
  // Set sequencer: one entry per cycle, X first
  localparam SEQ_IDLE = 1'b0;
  localparam SEQ_PUSH = 1'b1;

  reg        seq_state;
  reg  [1:0] seq_idx;
  reg [47:0] hold_set;
  reg        hold_temp;
  reg [11:0] cur_data;
  wire [1:0] last_idx;
  wire       wr_req;
  wire[15:0] wr_word;

  assign last_idx = hold_temp ? `ASF_TAG_T : `ASF_TAG_Z;
  assign wr_req   = (seq_state == SEQ_PUSH);

  // Pick the datum for the current slot of the set
  always @*
  begin
    case (seq_idx)
      `ASF_TAG_X: cur_data = hold_set[47:36];
      `ASF_TAG_Y: cur_data = hold_set[35:24];
      `ASF_TAG_Z: cur_data = hold_set[23:12];
      default:    cur_data = hold_set[11:0];
    endcase
  end

  // Tag, two sign copies, twelve data bits
  assign wr_word = {seq_idx, {2{cur_data[11]}}, cur_data};

  // A new set arriving mid-sequence is ignored; sets come far apart
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seq_state <= SEQ_IDLE;
      seq_idx   <= 2'b00;
      hold_set  <= 48'h0000_0000_0000;
      hold_temp <= 1'b0;
    end
    else
    begin
      case (seq_state)
        SEQ_IDLE:
          if (smp_valid && mode != `ASF_MODE_OFF)
          begin
            hold_set  <= {smp_x, smp_y, smp_z, smp_t};
            hold_temp <= temp_en;
            seq_idx   <= `ASF_TAG_X;
            seq_state <= SEQ_PUSH;
          end
        SEQ_PUSH:
          if (mode == `ASF_MODE_OFF || seq_idx == last_idx)
            seq_state <= SEQ_IDLE;
          else
            seq_idx <= seq_idx + 2'b01;
        default:
          seq_state <= SEQ_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Occupancy and policy decisions
  reg  [AW-1:0] wr_ptr;
  reg  [AW-1:0] rd_ptr;
  reg  [CW-1:0] cnt;
  reg           trig;
  reg           phase_hi;
  reg     [7:0] hi_byte;
  wire   [15:0] rd_word;
  wire          full;
  wire          empty;
  wire          pop;
  reg           accept;
  reg           drop;
  reg           ovr_set;
  reg  [CW-1:0] next_cnt;

  assign full  = (cnt == DEPTH[CW-1:0]);
  assign empty = (cnt == {CW{1'b0}});
  // A low-byte request takes the whole entry out; a clash with a new command pops nothing
  assign pop   = rd_byte_req && !rd_cmd_start && !phase_hi && !empty;

  // Per-cycle verdict on the entry the sequencer offers
  always @*
  begin
    accept  = 1'b0;
    drop    = 1'b0;
    ovr_set = 1'b0;
    if (wr_req)
      case (mode)
        `ASF_MODE_OLDEST:
        begin
          accept  = !full || pop;
          ovr_set = full && !pop;
        end
        `ASF_MODE_STREAM:
        begin
          accept  = 1'b1;
          drop    = full && !pop;
          ovr_set = full && !pop;
        end
        `ASF_MODE_TRIG:
        begin
          if (trig)
            accept = !full || pop;
          else
          begin
            accept = 1'b1;
            // Keep only the pre-event window before the trigger
            drop   = !pop && !empty && ({1'b0, wm_lvl} <= cnt || full);
          end
        end
        default:
          accept = 1'b0;
      endcase
  end

  // Count follows push, pop and drop; pop and drop never coincide
  always @*
  begin
    next_cnt = cnt;
    if (accept && !(pop || drop))
      next_cnt = cnt + {{(CW-1){1'b0}}, 1'b1};
    else if (!accept && (pop || drop))
      next_cnt = cnt - {{(CW-1){1'b0}}, 1'b1};
  end

  // Pointers, count and trigger latch
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      cnt    <= {CW{1'b0}};
      trig   <= 1'b0;
    end
    else if (mode == `ASF_MODE_OFF)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      cnt    <= {CW{1'b0}};
      trig   <= 1'b0;
    end
    else
    begin
      if (accept)
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      if (pop || drop)
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      cnt <= next_cnt;
      // One-shot: only the first event while armed counts
      if (mode != `ASF_MODE_TRIG)
        trig <= 1'b0;
      else if (act_event)
        trig <= 1'b1;
    end
  end

  asf_sample_mem
  #(
    .WIDTH (16),
    .DEPTH (DEPTH),
    .AW    (AW)
  )
  u_mem
  (
    .clk_sys (clk_sys),
    .wr_en   (accept),
    .wr_addr (wr_ptr),
    .wr_data (wr_word),
    .rd_addr (rd_ptr),
    .rd_data (rd_word)
  );

  // ==========================================================
  // Byte read port: low byte, then high byte of the same entry
  // An odd byte count loses the last high byte; a new read command resets the phase to the low byte
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_hi      <= 1'b0;
      hi_byte       <= 8'h00;
      rd_byte_data  <= 8'h00;
      rd_byte_valid <= 1'b0;
    end
    else
    begin
      rd_byte_valid <= rd_byte_req;
      if (rd_cmd_start)
        phase_hi <= 1'b0;
      else if (rd_byte_req)
      begin
        phase_hi <= !phase_hi;
        if (!phase_hi)
        begin
          rd_byte_data <= empty ? 8'h00 : rd_word[7:0];
          hi_byte      <= empty ? 8'h00 : rd_word[15:8];
        end
        else
          rd_byte_data <= hi_byte;
      end
    end
  end

  // ==========================================================
  // Status indications
  // Overrun: a read in the same cycle as a write to a full buffer averts the loss and clears the flag
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_ready     <= 1'b0;
      flag_watermark <= 1'b0;
      flag_overrun   <= 1'b0;
      level          <= {CW{1'b0}};
    end
    else
    begin
      level          <= (mode == `ASF_MODE_OFF) ? {CW{1'b0}} : next_cnt;
      flag_ready     <= (mode != `ASF_MODE_OFF) && (next_cnt != {CW{1'b0}});
      // Level of zero holds the flag up by design
      flag_watermark <= (mode != `ASF_MODE_OFF) && ({1'b0, wm_lvl} <= next_cnt);
      if (mode == `ASF_MODE_OFF)
        flag_overrun <= 1'b0;
      else if (ovr_set)
        flag_overrun <= 1'b1;
      else if (pop)
        flag_overrun <= 1'b0;
    end
  end

endmodule

`default_nettype wire

//--- logic/asf_fifo_defs.vh
// Summary of operation
// - Buffer holds 512 entries, 170 or 128 sets
// - Mode 00 stores nothing, flushes contents
// - Mode 01 stops when full, resumes after reads
// - Mode 10 drops oldest entry to fit newest
// - Programmed level reached raises watermark indication in modes 01, 10 and 11
// - Mode 11 keeps programmed pre-event entries
// - 16-bit entry, low byte read first
// - Low twelve bits data, two sign copies
// - Top two bits tag X, Y, Z, temperature
// - Bytes read while empty return zero
// - Sets written X, Y, Z, then temperature
// - Partial sets stored when space runs short
// - Each entry read frees one slot
// - Ready, watermark and overrun indications provided
// - Configuration at offsets 0x28 and 0x29
// - Watermark set while count at or above level
// - Ready set while any entry is stored
// - Overrun on replaced data or no space, in modes 01 and 10 only
// - Overrun cleared by reads or disabling
`ifndef ASF_FIFO_DEFS_VH
`define ASF_FIFO_DEFS_VH

// ==========================================================
// Register map
`define ASF_ADDR_CONTROL      8'h28
`define ASF_ADDR_SAMPLE_COUNT 8'h29
`define ASF_RST_CONTROL       8'h00
`define ASF_RST_SAMPLE_COUNT  8'h80

// ==========================================================
// Control field positions
`define ASF_CTL_MODE_LSB      0
`define ASF_CTL_MODE_MSB      1
`define ASF_CTL_TEMP_BIT      2
`define ASF_CTL_HIGH_BIT      3

// ==========================================================
// Policies and entry tags
`define ASF_MODE_OFF          2'b00
`define ASF_MODE_OLDEST       2'b01
`define ASF_MODE_STREAM       2'b10
`define ASF_MODE_TRIG         2'b11
`define ASF_TAG_X             2'b00
`define ASF_TAG_Y             2'b01
`define ASF_TAG_Z             2'b10
`define ASF_TAG_T             2'b11

// ==========================================================
// Geometry
`define ASF_DEPTH             512
`define ASF_ADDR_W            9
`define ASF_CNT_W             10

`endif

//--- logic/asf_sample_mem.v
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Entry storage: clocked write, direct read
module asf_sample_mem
#(
  parameter WIDTH = 16,
  parameter DEPTH = 512,
  parameter AW    = 9
)
(
  input  wire             clk_sys,
  input  wire             wr_en,
  input  wire [AW-1:0]    wr_addr,
  input  wire [WIDTH-1:0] wr_data,
  input  wire [AW-1:0]    rd_addr,
  output wire [WIDTH-1:0] rd_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // Read is combinational so a pop can latch the word in its own cycle
  assign rd_data = mem[rd_addr];

  // Contents need no reset; the pointers decide what is valid
  always @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

endmodule

`default_nettype wire

//--- bench/asf_fifo_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ====
// Port checker for the sample buffer
module asf_fifo_chk
#(
  parameter CW = 10
)
(
  input wire logic          clk_sys,
  input wire logic          rstn,
  input wire logic          reg_wr_en,
  input wire logic          reg_rd_en,
  input wire logic [7:0]    reg_addr,
  input wire logic [7:0]    reg_wdata,
  input wire logic [7:0]    reg_rdata,
  input wire logic          rd_cmd_start,
  input wire logic          rd_byte_req,
  input wire logic          rd_byte_valid,
  input wire logic          flag_ready,
  input wire logic          flag_overrun,
  input wire logic [CW-1:0] level
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // First byte request of a read command pops an entry
  sequence first_byte;
    rd_cmd_start ##1 (rd_byte_req && !rd_cmd_start);
  endsequence
  // Control write selecting the disabled policy
  sequence off_write;
    reg_wr_en && reg_addr == 8'h28 && reg_wdata[1:0] == 2'b00;
  endsequence
  AST_READY: assert property (flag_ready == (level != 0))
    else $error("ready flag disagrees with level");
  AST_DEPTH: assert property (level <= 512)
    else $error("level above buffer depth");
  AST_GROW: assert property (level <= $past(level) + 1)
    else $error("more than one entry written per cycle");
  AST_BYTE: assert property (rd_byte_req && !rd_cmd_start |=> rd_byte_valid)
    else $error("byte request not answered");
  AST_NOBYTE: assert property (!rd_byte_req |=> !rd_byte_valid)
    else $error("byte answered without request");
  AST_POP: assert property (first_byte ##0 (level != 0) |=> level <= $past(level))
    else $error("read did not free a slot");
  AST_OFF: assert property (off_write |=> ##1 (level == 0 && !flag_ready && !flag_overrun))
    else $error("disable left contents or flags");
  AST_OVR: assert property ($rose(flag_overrun) |-> $past(level) == 512)
    else $error("overrun raised while not full");
  AST_UNMAP: assert property (reg_rd_en && reg_addr != 8'h28 && reg_addr != 8'h29 |=> reg_rdata == 8'h00)
    else $error("unmapped offset read nonzero");
endmodule
bind asf_sample_fifo asf_fifo_chk #(.CW(CW)) asf_fifo_chk_i (
  .clk_sys(clk_sys), .rstn(rstn), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .rd_cmd_start(rd_cmd_start), .rd_byte_req(rd_byte_req), .rd_byte_valid(rd_byte_valid),
  .flag_ready(flag_ready), .flag_overrun(flag_overrun), .level(level));
`default_nettype wire

//--- bench/asf_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ====
// Host reading the buffer through its serial read command
module asf_host_model
(
  input  wire logic       clk_sys,
  output var  logic       rd_cmd_start,
  output var  logic       rd_byte_req,
  input  wire logic [7:0] rd_byte_data,
  input  wire logic       rd_byte_valid
);
  logic [7:0] byte_q[$];
  initial
  begin
    rd_cmd_start = 1'b0;
    rd_byte_req = 1'b0;
  end
  // Every answered byte is kept; the bench pairs them
  always @(posedge clk_sys)
    if (rd_byte_valid)
      byte_q.push_back(rd_byte_data);
  // Whole entries only, so the byte count is always even; gap makes a slow host
  task automatic read_entries(input int n, input int gap);
    @(negedge clk_sys);
    rd_cmd_start = 1'b1;
    @(negedge clk_sys);
    rd_cmd_start = 1'b0;
    for (int i = 0; i < 2 * n; i++)
    begin
      rd_byte_req = 1'b1;
      @(negedge clk_sys);
      if (gap > 0)
      begin
        rd_byte_req = 1'b0;
        repeat (gap) @(negedge clk_sys);
      end
    end
    rd_byte_req = 1'b0;
    @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire

//--- bench/test_accel_sample_fifo.sv
`timescale 1ns/100ps
`default_nettype none
// ====
// Bench for the sample buffer
module test_accel_sample_fifo;
  logic        clk_sys = 1'b0, rstn = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
  logic        smp_valid = 1'b0, act_event = 1'b0, temp = 1'b0, armed = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [11:0] smp_x = 12'h000, smp_y = 12'h000, smp_z = 12'h000, smp_t = 12'h000;
  logic [1:0]  mode = 2'b00;
  logic [15:0] exp_q[$];
  wire logic [7:0] reg_rdata, rd_byte_data;
  wire logic       rd_byte_valid, flag_ready, flag_watermark, flag_overrun, rd_cmd_start, rd_byte_req;
  wire logic [9:0] level;
  int          err_total = 0, n_compared = 0, wm = 0, seed = 32'hcb72;

  asf_sample_fifo asf_sample_fifo_i (.clk_sys(clk_sys), .rstn(rstn), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .smp_valid(smp_valid), .smp_x(smp_x), .smp_y(smp_y), .smp_z(smp_z), .smp_t(smp_t),
    .act_event(act_event), .rd_cmd_start(rd_cmd_start), .rd_byte_req(rd_byte_req),
    .rd_byte_data(rd_byte_data), .rd_byte_valid(rd_byte_valid), .flag_ready(flag_ready),
    .flag_watermark(flag_watermark), .flag_overrun(flag_overrun), .level(level));
  asf_host_model asf_host_model_i (.clk_sys(clk_sys), .rd_cmd_start(rd_cmd_start),
    .rd_byte_req(rd_byte_req), .rd_byte_data(rd_byte_data), .rd_byte_valid(rd_byte_valid));

  always #25 clk_sys = ~clk_sys;

  // ====
  // Checking and bus tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr_en = 1'b0;
  endtask
  task automatic reg_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd_en = 1'b0;
    chk(16'(reg_rdata), 16'(e));
  endtask
  // Reference model: expected entry and policy on arrival
  function automatic logic [15:0] entry(input logic [1:0] tag, input logic [11:0] d);
    return {tag, {2{d[11]}}, d};
  endfunction
  task automatic put(input logic [15:0] e);
    if (mode == 2'b10 && exp_q.size() == 512)
      void'(exp_q.pop_front());
    if (mode == 2'b11 && !armed && exp_q.size() != 0 && exp_q.size() >= wm)
      void'(exp_q.pop_front());
    if (exp_q.size() < 512)
      exp_q.push_back(e);
  endtask
  task automatic set_ctl(input logic [1:0] m, input logic t, input int w);
    logic [8:0] wv;
    wv = w[8:0];
    if (m == 2'b00)
      exp_q.delete();
    armed = 1'b0;
    mode = m;
    temp = t;
    wm = w;
    reg_wr(8'h29, wv[7:0]);
    reg_wr(8'h28, {4'h0, wv[8], t, m});
  endtask
  // Sets stay six cycles apart, above the five the sequencer needs
  task automatic push(input logic [47:0] v);
    @(negedge clk_sys);
    {smp_x, smp_y, smp_z, smp_t} = v;
    smp_valid = 1'b1;
    @(negedge clk_sys);
    smp_valid = 1'b0;
    if (mode != 2'b00)
    begin
      put(entry(2'b00, v[47:36]));
      put(entry(2'b01, v[35:24]));
      put(entry(2'b10, v[23:12]));
      if (temp)
        put(entry(2'b11, v[11:0]));
    end
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic push_rnd(input int n);
    logic [63:0] r;
    repeat (n)
    begin
      r = {$random(seed), $random(seed)};
      push(r[47:0]);
    end
  endtask
  task automatic state(input logic ovr);
    @(negedge clk_sys);
    chk(16'(level), 16'(exp_q.size()));
    chk(16'(flag_ready), 16'(exp_q.size() != 0));
    chk(16'(flag_overrun), 16'(ovr));
    if (mode != 2'b00)
      chk(16'(flag_watermark), 16'(exp_q.size() >= wm));
  endtask
  task automatic drain(input int n, input int gap);
    logic [7:0] b[$];
    asf_host_model_i.read_entries(n, gap);
    b = asf_host_model_i.byte_q;
    asf_host_model_i.byte_q.delete();
    chk(16'(b.size()), 16'(2 * n));
    for (int i = 0; i + 1 < b.size(); i += 2)
      chk({b[i+1], b[i]}, exp_q.size() != 0 ? exp_q.pop_front() : 16'h0000);
  endtask

  // ====
  // Main sequence
  initial
  begin
    repeat (10) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (3) @(negedge clk_sys);
    reg_chk(8'h28, 8'h00);
    reg_chk(8'h29, 8'h80);
    reg_chk(8'h2a, 8'h00);
    set_ctl(2'b01, 1'b1, 20);
    reg_chk(8'h28, 8'h05);
    $display("registers done");
    push(48'h8007_ff00_1fff);
    state(1'b0);
    push_rnd(130);
    state(1'b1);
    drain(1, 2);
    state(1'b0);
    push_rnd(1);
    state(1'b1);
    drain(514, 0);
    state(1'b0);
    $display("oldest done");
    set_ctl(2'b10, 1'b0, 266);
    push_rnd(88);
    state(1'b0);
    push_rnd(1);
    state(1'b0);
    push_rnd(90);
    state(1'b1);
    drain(4, 0);
    state(1'b0);
    push_rnd(2);
    state(1'b1);
    set_ctl(2'b00, 1'b0, 266);
    push_rnd(1);
    state(1'b0);
    $display("stream done");
    set_ctl(2'b11, 1'b0, 4);
    push_rnd(5);
    state(1'b0);
    @(negedge clk_sys);
    act_event = 1'b1;
    @(negedge clk_sys);
    act_event = 1'b0;
    armed = 1'b1;
    push_rnd(3);
    state(1'b0);
    drain(20, 1);
    push_rnd(175);
    state(1'b0);
    drain(2, 0);
    state(1'b0);
    $display("triggered done");
    print_verdict;
  end
  // Watchdog against a hang
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    err_total++;
    print_verdict;
  end
endmodule
`default_nettype wire
